/* include/lcd_pkg.sv */
// constants shared by the lane coding datapath
package lcd_pkg;
  localparam int LANES = 4;
  localparam int EL_W = 36;
  localparam int CW_W = 33;
  localparam int WORD_W = 32;
  localparam int WBE_W = 4;
  localparam int PAY_W = 135;
  localparam int ECC_W = 9;
  localparam int SYN_W = 8;
  localparam int CHUNK_W = 128;
  localparam int BE_W = 16;
  localparam int LAST_W = 2;
  localparam int EGW = CHUNK_W + BE_W + LAST_W;
  localparam int FIFO_DEPTH = 4;
  localparam int ID_W = 2;
  localparam int SYNC_BIT = 134;
  // comma-bearing lane sync word, upper 34 bits; low 2 bits carry the lane id
  localparam logic [33:0] SYNC_HI = 34'h2fa3c5a0f;
  localparam logic [35:0] LFSR_SEED = 36'h0f0f0f0f1;
  localparam int LFSR_TAP = 24;
  localparam int HPOS_FIRST = 3;
  localparam logic [3:0] BE_FULL = 4'hf;
  localparam logic [7:0] OCT_ON = 8'hff;
  localparam logic [7:0] OCT_OFF = 8'h00;
  localparam logic [1:0] LAST_EL = 2'h3;
endpackage

/* rtl/lcd_datapath.sv */
// lane coding datapath: fifo, transmit coder/scrambler, receive aligner/decoder
// Function
// - slice 128-bit chunks into 32-bit words
// - code each word with enables to 33 bits
// - four words, last flags, sync, ECC: 144
// - split block into four 36-bit lane elements
// - scramble each lane independently
// - receive: align, sync, descramble, correct, decode
// - command word precedes its data in fifo
// - data enters in whole eight-byte octets
// - at most 16 bytes per clock
// - one-lane or four-lane operation
// - detect and fix inverted lane polarity
// - identify logical lane, reorder lanes
// - internal loopback of transmit to receive
// - separate ingress and egress fifos
// - sync word holds comma for alignment
// - ignore commas once lane is active
`timescale 1ns/1ps

module lcd_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wptr;
  logic [AW-1:0] rptr;
  logic [CW-1:0] count;
  logic push;
  logic pop;

  // handshake terms
  assign in_ready = count != CW'(DEPTH);
  assign out_valid = count != '0;
  assign out_data = mem[rptr];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wptr <= (wptr == AW'(DEPTH - 1)) ? '0 : AW'(wptr + 1'b1);
      end
      if (pop) begin
        rptr <= (rptr == AW'(DEPTH - 1)) ? '0 : AW'(rptr + 1'b1);
      end
      if (push != pop) begin
        count <= push ? CW'(count + 1'b1) : CW'(count - 1'b1);
      end
    end
  end
endmodule

module lcd_datapath (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // mode
  input wire logic four_lane,
  input wire logic loopback,
  // egress chunks from the link transfer layer
  input wire logic eg_valid,
  output logic eg_ready,
  input wire logic [lcd_pkg::CHUNK_W-1:0] eg_data,
  input wire logic [lcd_pkg::BE_W-1:0] eg_be,
  input wire logic [lcd_pkg::LAST_W-1:0] eg_last,
  output logic eg_reject,
  // serializer lanes
  output logic [lcd_pkg::LANES-1:0][lcd_pkg::EL_W-1:0] tx_lane_data,
  input wire logic [lcd_pkg::LANES-1:0][lcd_pkg::EL_W-1:0] rx_lane_data,
  output logic [lcd_pkg::LANES-1:0] sym_align_en,
  output logic [lcd_pkg::LANES-1:0] lane_active_state,
  // ingress chunks to the link transfer layer
  output logic ig_valid,
  input wire logic ig_ready,
  output logic [lcd_pkg::CHUNK_W-1:0] ig_data,
  output logic [lcd_pkg::BE_W-1:0] ig_be,
  output logic [lcd_pkg::LAST_W-1:0] ig_last,
  output logic ecc_corr,
  output logic rx_err
);
  localparam int L = lcd_pkg::LANES;
  localparam int E = lcd_pkg::EL_W;

  // check bits of a shortened SEC-DED code over the payload
  function automatic logic [lcd_pkg::ECC_W-1:0] lcd_ecc(input logic [lcd_pkg::PAY_W-1:0] d);
    logic [lcd_pkg::ECC_W-1:0] c;
    int pos;
    c = '0;
    pos = lcd_pkg::HPOS_FIRST;
    for (int j = 0; j < lcd_pkg::PAY_W; j++) begin
      if ((pos & (pos - 1)) == 0) begin
        pos = pos + 1;
      end
      for (int k = 0; k < lcd_pkg::SYN_W; k++) begin
        if (pos[k]) begin
          c[k] = c[k] ^ d[j];
        end
      end
      pos = pos + 1;
    end
    c[lcd_pkg::SYN_W] = ^{c[lcd_pkg::SYN_W-1:0], d};
    return c;
  endfunction

  // flip the payload bit at the syndrome's position
  function automatic logic [lcd_pkg::PAY_W-1:0] lcd_fix(input logic [lcd_pkg::PAY_W-1:0] d,
                                                          input logic [lcd_pkg::SYN_W-1:0] s);
    logic [lcd_pkg::PAY_W-1:0] r;
    int pos;
    r = d;
    pos = lcd_pkg::HPOS_FIRST;
    for (int j = 0; j < lcd_pkg::PAY_W; j++) begin
      if ((pos & (pos - 1)) == 0) begin
        pos = pos + 1;
      end
      if (lcd_pkg::SYN_W'(pos) == s) begin
        r[j] = ~r[j];
      end
      pos = pos + 1;
    end
    return r;
  endfunction

  // advance the lane scrambler by one element
  function automatic logic [lcd_pkg::EL_W-1:0] lcd_step(input logic [lcd_pkg::EL_W-1:0] s);
    logic [lcd_pkg::EL_W-1:0] r;
    r = s;
    for (int i = 0; i < lcd_pkg::EL_W; i++) begin
      r = {r[lcd_pkg::EL_W-2:0], r[lcd_pkg::EL_W-1] ^ r[lcd_pkg::LFSR_TAP]};
    end
    return r;
  endfunction

  logic legal;
  logic efo_valid;
  logic efo_ready;
  logic [lcd_pkg::EGW-1:0] efo_data;
  logic [lcd_pkg::PAY_W-1:0] pay;
  logic [4*E-1:0] blk;
  logic [4*E-1:0] tx_blk;
  logic tx_busy;
  logic [1:0] elc;
  logic tx_start;
  logic [L-1:0] sel_v;
  logic [L-1:0][E-1:0] sel_el;
  logic [L-1:0][E-1:0] tx_lfsr;

  // chunk must be whole octets and not empty
  assign legal = (eg_be[7:0] == lcd_pkg::OCT_ON || eg_be[7:0] == lcd_pkg::OCT_OFF) &&
                 (eg_be[15:8] == lcd_pkg::OCT_ON || eg_be[15:8] == lcd_pkg::OCT_OFF) &&
                 (eg_be != '0);

  // egress fifo, one 16-byte chunk per clock at most
  lcd_fifo #(.W(lcd_pkg::EGW), .DEPTH(lcd_pkg::FIFO_DEPTH)) u_egress (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(eg_valid & legal),
    .in_ready(eg_ready),
    .in_data({eg_last, eg_be, eg_data}),
    .out_valid(efo_valid),
    .out_ready(efo_ready),
    .out_data(efo_data)
  );

  // illegal chunk dropped and flagged
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      eg_reject <= 1'b0;
    end else begin
      eg_reject <= eg_valid & ~legal;
    end
  end

  // slice, code and protect one chunk
  always_comb begin
    pay = '0;
    for (int k = 0; k < 4; k++) begin
      if (efo_data[lcd_pkg::CHUNK_W + 4*k +: lcd_pkg::WBE_W] == lcd_pkg::BE_FULL) begin
        pay[lcd_pkg::CW_W*k +: lcd_pkg::CW_W] = {1'b0, efo_data[lcd_pkg::WORD_W*k +: lcd_pkg::WORD_W]};
      end else begin
        pay[lcd_pkg::CW_W*k +: lcd_pkg::CW_W] = {1'b1, {lcd_pkg::WORD_W{1'b0}}};
      end
    end
    pay[lcd_pkg::SYNC_BIT] = 1'b1;
    pay[4*lcd_pkg::CW_W +: lcd_pkg::LAST_W] = efo_data[lcd_pkg::EGW-1 -: lcd_pkg::LAST_W];
    blk = {lcd_ecc(pay), pay};
  end

  assign efo_ready = ~tx_busy;
  assign tx_start = efo_valid & ~tx_busy;

  // single-lane sequencing of the remaining elements
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_busy <= 1'b0;
      elc <= '0;
      tx_blk <= '0;
    end else if (tx_start && !four_lane) begin
      tx_blk <= blk;
      tx_busy <= 1'b1;
      elc <= 2'h1;
    end else if (tx_busy) begin
      elc <= 2'(elc + 1'b1);
      tx_busy <= elc != lcd_pkg::LAST_EL;
    end
  end

  // element selection per lane
  always_comb begin
    for (int i = 0; i < L; i++) begin
      sel_v[i] = four_lane & tx_start;
      sel_el[i] = blk[E*i +: E];
    end
    if (!four_lane) begin
      sel_v[0] = tx_start | tx_busy;
      sel_el[0] = tx_busy ? tx_blk[E*elc +: E] : blk[E-1:0];
    end
  end

  logic [L-1:0][E-1:0] rx_raw;
  logic [L-1:0][E-1:0] rx_w;
  logic [L-1:0] is_sync;
  logic [L-1:0] inv;
  logic [L-1:0][lcd_pkg::ID_W-1:0] lid;
  logic [L-1:0][E-1:0] rx_lfsr;
  logic [L-1:0][E-1:0] rx_el;
  logic [L-1:0] rx_ev;
  logic [L-1:0] rx_es;

  for (genvar i = 0; i < L; i++) begin : g_lane
    // scrambled element or unscrambled sync word
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        tx_lane_data[i] <= '0;
        tx_lfsr[i] <= lcd_pkg::LFSR_SEED;
      end else if (sel_v[i]) begin
        tx_lane_data[i] <= sel_el[i] ^ tx_lfsr[i];
        tx_lfsr[i] <= lcd_step(tx_lfsr[i]);
      end else begin
        tx_lane_data[i] <= {lcd_pkg::SYNC_HI, lcd_pkg::ID_W'(i)};
        tx_lfsr[i] <= lcd_pkg::LFSR_SEED;
      end
    end

    assign rx_raw[i] = loopback ? tx_lane_data[i] : rx_lane_data[i];
    assign rx_w[i] = rx_raw[i] ^ {E{inv[i]}};
    assign is_sync[i] = rx_w[i][E-1:lcd_pkg::ID_W] == lcd_pkg::SYNC_HI;
    assign sym_align_en[i] = ~lane_active_state[i];

    // symbol lock, polarity and lane identity
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        lane_active_state[i] <= 1'b0;
        inv[i] <= 1'b0;
        lid[i] <= '0;
      end else if (!lane_active_state[i]) begin
        if (rx_raw[i][E-1:lcd_pkg::ID_W] == lcd_pkg::SYNC_HI) begin
          lane_active_state[i] <= 1'b1;
          inv[i] <= 1'b0;
          lid[i] <= rx_raw[i][lcd_pkg::ID_W-1:0];
        end else if (~rx_raw[i][E-1:lcd_pkg::ID_W] == lcd_pkg::SYNC_HI) begin
          lane_active_state[i] <= 1'b1;
          inv[i] <= 1'b1;
          lid[i] <= ~rx_raw[i][lcd_pkg::ID_W-1:0];
        end
      end
    end

    // descrambler, reseeded by each sync word
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        rx_lfsr[i] <= lcd_pkg::LFSR_SEED;
        rx_el[i] <= '0;
        rx_ev[i] <= 1'b0;
        rx_es[i] <= 1'b0;
      end else begin
        rx_el[i] <= rx_w[i] ^ rx_lfsr[i];
        rx_ev[i] <= lane_active_state[i] & ~is_sync[i];
        rx_es[i] <= lane_active_state[i] & is_sync[i];
        if (lane_active_state[i]) begin
          rx_lfsr[i] <= is_sync[i] ? lcd_pkg::LFSR_SEED : lcd_step(rx_lfsr[i]);
        end
      end
    end
  end

  logic [L-1:0][E-1:0] lel;
  logic [L-1:0] lv;
  logic [L-1:0] ls;
  logic [4*E-1:0] rx_blk;
  logic rx_blk_v;
  logic [1:0] rcnt;

  // logical lane k from the physical lane that named itself k
  always_comb begin
    for (int k = 0; k < L; k++) begin
      lel[k] = '0;
      lv[k] = 1'b0;
      ls[k] = 1'b0;
      for (int p = 0; p < L; p++) begin
        if (lane_active_state[p] && lid[p] == lcd_pkg::ID_W'(k)) begin
          lel[k] = rx_el[p];
          lv[k] = rx_ev[p];
          ls[k] = rx_es[p];
        end
      end
    end
  end

  // block reassembly; in single-lane mode a sync word restarts the element count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_blk <= '0;
      rx_blk_v <= 1'b0;
      rcnt <= '0;
    end else begin
      rx_blk_v <= 1'b0;
      if (four_lane) begin
        rcnt <= '0;
        if (&lv) begin
          rx_blk <= {lel[3], lel[2], lel[1], lel[0]};
          rx_blk_v <= 1'b1;
        end
      end else if (ls[0]) begin
        rcnt <= '0;
      end else if (lv[0]) begin
        rx_blk[E*rcnt +: E] <= lel[0];
        rcnt <= 2'(rcnt + 1'b1);
        rx_blk_v <= rcnt == lcd_pkg::LAST_EL;
      end
    end
  end

  logic [lcd_pkg::ECC_W-1:0] calc;
  logic [lcd_pkg::SYN_W-1:0] syn;
  logic perr;
  logic bad;
  logic [lcd_pkg::PAY_W-1:0] fixed;
  logic [lcd_pkg::EGW-1:0] ifo_in;
  logic push;
  logic ifo_ready;

  // error correction and 33-to-32 decoding
  always_comb begin
    calc = lcd_ecc(rx_blk[lcd_pkg::PAY_W-1:0]);
    syn = calc[lcd_pkg::SYN_W-1:0] ^ rx_blk[lcd_pkg::PAY_W +: lcd_pkg::SYN_W];
    perr = ^rx_blk;
    bad = (syn != '0) & ~perr;
    fixed = (syn != '0 && perr) ? lcd_fix(rx_blk[lcd_pkg::PAY_W-1:0], syn) : rx_blk[lcd_pkg::PAY_W-1:0];
    ifo_in = '0;
    ifo_in[lcd_pkg::EGW-1 -: lcd_pkg::LAST_W] = fixed[4*lcd_pkg::CW_W +: lcd_pkg::LAST_W];
    for (int k = 0; k < 4; k++) begin
      if (!fixed[lcd_pkg::CW_W*k + lcd_pkg::WORD_W]) begin
        ifo_in[lcd_pkg::WORD_W*k +: lcd_pkg::WORD_W] = fixed[lcd_pkg::CW_W*k +: lcd_pkg::WORD_W];
        ifo_in[lcd_pkg::CHUNK_W + 4*k +: lcd_pkg::WBE_W] = lcd_pkg::BE_FULL;
      end
    end
  end

  assign push = rx_blk_v & ~bad & fixed[lcd_pkg::SYNC_BIT];

  // ingress fifo toward the link transfer layer
  lcd_fifo #(.W(lcd_pkg::EGW), .DEPTH(lcd_pkg::FIFO_DEPTH)) u_ingress (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(push),
    .in_ready(ifo_ready),
    .in_data(ifo_in),
    .out_valid(ig_valid),
    .out_ready(ig_ready),
    .out_data({ig_last, ig_be, ig_data})
  );

  // receive event pulses
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ecc_corr <= 1'b0;
      rx_err <= 1'b0;
    end else begin
      ecc_corr <= rx_blk_v & (syn != '0) & perr;
      rx_err <= rx_blk_v & (bad | ~fixed[lcd_pkg::SYNC_BIT] | ~ifo_ready);
    end
  end

  sequence s_single_run;
    tx_busy [*3] ##1 !tx_busy;
  endsequence
  property p_single_order;
    @(posedge clk) disable iff (!rst_n) tx_start && !four_lane |=> s_single_run;
  endproperty
  a_single_order: assert property (p_single_order) else $error("single lane run not four elements");
  property p_reject;
    @(posedge clk) disable iff (!rst_n) eg_valid && eg_be == '0 |=> eg_reject;
  endproperty
  a_reject: assert property (p_reject) else $error("empty chunk not rejected");
  property p_quad;
    @(posedge clk) disable iff (!rst_n) tx_start && four_lane |=> !tx_busy && tx_lfsr[3] != lcd_pkg::LFSR_SEED;
  endproperty
  a_quad: assert property (p_quad) else $error("four lane block not sent at once");
  property p_scr_seed;
    @(posedge clk) disable iff (!rst_n) !sel_v[1] |=> tx_lfsr[1] == lcd_pkg::LFSR_SEED;
  endproperty
  a_scr_seed: assert property (p_scr_seed) else $error("scrambler not reseeded on sync");
  property p_hold_active;
    @(posedge clk) disable iff (!rst_n) lane_active_state[0] |=> lane_active_state[0] && $stable(inv[0]);
  endproperty
  a_hold_active: assert property (p_hold_active) else $error("active lane relocked");
  property p_pol;
    @(posedge clk) disable iff (!rst_n)
      !lane_active_state[2] && ~rx_raw[2][E-1:lcd_pkg::ID_W] == lcd_pkg::SYNC_HI |=> inv[2] && !sym_align_en[2];
  endproperty
  a_pol: assert property (p_pol) else $error("inverted lane not corrected");
  property p_loop;
    @(posedge clk) disable iff (!rst_n)
      loopback && !lane_active_state[0] && tx_lane_data[0][E-1:lcd_pkg::ID_W] == lcd_pkg::SYNC_HI
      |=> lane_active_state[0] && lid[0] == '0;
  endproperty
  a_loop: assert property (p_loop) else $error("loopback did not lock lane");
  property p_corr;
    @(posedge clk) disable iff (!rst_n) rx_blk_v && syn != '0 && perr && ifo_ready && fixed[lcd_pkg::SYNC_BIT]
      |=> ecc_corr && !rx_err;
  endproperty
  a_corr: assert property (p_corr) else $error("single error not corrected");
endmodule

/* verification/lcd_far_end.sv */
// far-end model: lane wiring that sends our lane words back, rotated and optionally inverted
`timescale 1ns/1ps

module lcd_far_end (
  // clock
  input wire logic clk,
  // wiring faults and release, set by the bench
  input wire logic mute,
  input wire logic [1:0] rot,
  input wire logic [3:0] inv,
  input wire logic [1:0] flip,
  // lanes
  input wire logic [lcd_pkg::LANES-1:0][lcd_pkg::EL_W-1:0] tx_lane,
  output logic [lcd_pkg::LANES-1:0][lcd_pkg::EL_W-1:0] rx_lane
);
  logic [lcd_pkg::EL_W-1:0] hit;

  // forced bit errors for wire 0, bits 5 and 9
  assign hit = {26'h0, flip[1], 3'h0, flip[0], 5'h0};

  // each wire carries a rotated logical lane, optionally inverted
  always_ff @(posedge clk) begin
    for (int p = 0; p < lcd_pkg::LANES; p++) begin
      if (mute) begin
        rx_lane[p] <= ~rx_lane[p]; // released wire toggles every cycle
      end else if (p == 0 && tx_lane[2'(p + rot)][lcd_pkg::EL_W-1:lcd_pkg::ID_W] != lcd_pkg::SYNC_HI) begin
        rx_lane[p] <= tx_lane[2'(p + rot)] ^ {lcd_pkg::EL_W{inv[p]}} ^ hit; // errors on data words only
      end else begin
        rx_lane[p] <= tx_lane[2'(p + rot)] ^ {lcd_pkg::EL_W{inv[p]}};
      end
    end
  end
endmodule

/* verification/tb.sv */
// self-checking bench for the lane coding datapath
`timescale 1ns/1ps

module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic four_lane = 1'b1;
  logic loopback = 1'b0;
  logic eg_valid = 1'b0;
  logic eg_ready;
  logic [127:0] eg_data = '0;
  logic [15:0] eg_be = '0;
  logic [1:0] eg_last = '0;
  logic eg_reject;
  logic [3:0][35:0] tx_lane_data;
  logic [3:0][35:0] rx_lane_data;
  logic [3:0] sym_align_en;
  logic [3:0] lane_active_state;
  logic ig_valid;
  logic ig_ready = 1'b0;
  logic [127:0] ig_data;
  logic [15:0] ig_be;
  logic [1:0] ig_last;
  logic ecc_corr;
  logic rx_err;
  logic mute = 1'b0;
  logic [1:0] rot = 2'h0;
  logic [3:0] inv = 4'h0;
  logic [1:0] flip = 2'h0;
  int fixes = 0;
  int err_total = 0;
  int tests_run = 0;
  int cycles = 0;
  int drops = 0;

  lcd_datapath u_dut (.clk(clk), .rst_n(rst_n), .four_lane(four_lane), .loopback(loopback),
    .eg_valid(eg_valid), .eg_ready(eg_ready), .eg_data(eg_data), .eg_be(eg_be), .eg_last(eg_last),
    .eg_reject(eg_reject), .tx_lane_data(tx_lane_data), .rx_lane_data(rx_lane_data),
    .sym_align_en(sym_align_en), .lane_active_state(lane_active_state), .ig_valid(ig_valid),
    .ig_ready(ig_ready), .ig_data(ig_data), .ig_be(ig_be), .ig_last(ig_last),
    .ecc_corr(ecc_corr), .rx_err(rx_err));

  lcd_far_end u_far (.clk(clk), .mute(mute), .rot(rot), .inv(inv), .flip(flip), .tx_lane(tx_lane_data),
    .rx_lane(rx_lane_data));

  // clock and hang guard
  always #5 clk = ~clk;
  always @(negedge clk) begin
    cycles++;
    if (rx_err === 1'b1) drops++;
    if (ecc_corr === 1'b1) fixes++;
    if (cycles == 5000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("checks %0d, mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [145:0] exp, logic [145:0] got);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask

  // reset for six cycles with the given modes; called at a falling edge
  task automatic do_reset(logic fl, logic lb);
    rst_n = 1'b0;
    four_lane = fl;
    loopback = lb;
    repeat (6) @(negedge clk);
    chk("reset state", {4'h0, 4'hf, 1'b1}, {lane_active_state, sym_align_en, eg_ready});
    rst_n = 1'b1;
  endtask

  // present one chunk until the fifo takes it; returns one falling edge later
  task automatic push(logic [127:0] d, logic [15:0] be, logic [1:0] last);
    int n;
    n = 0;
    eg_valid = 1'b1;
    eg_data = d;
    eg_be = be;
    eg_last = last;
    while (eg_ready !== 1'b1 && n < 20) begin
      @(negedge clk);
      n++;
    end
    @(negedge clk);
  endtask

  // wait for one ingress chunk, judge it with masked words zeroed, then take it
  task automatic pull(logic [127:0] d, logic [15:0] be, logic [1:0] last);
    int n;
    logic [127:0] m;
    n = 0;
    for (int k = 0; k < 4; k++) m[32*k +: 32] = be[4*k] ? d[32*k +: 32] : 32'h0;
    while (ig_valid !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("ingress chunk", {be, last, m}, {ig_be, ig_last, ig_data});
    ig_ready = 1'b1;
    @(negedge clk);
    ig_ready = 1'b0;
    @(negedge clk);
  endtask

  // idle lanes carry sync words; swapped and inverted wires still lock
  task automatic t_sync();
    rot = 2'h1;
    inv = 4'h4;
    do_reset(1'b1, 1'b0);
    @(negedge clk);
    for (int k = 0; k < 4; k++) chk("sync word", {lcd_pkg::SYNC_HI, 2'(k)}, tx_lane_data[k]);
    repeat (6) @(negedge clk);
    chk("lane lock", {4'hf, 4'h0}, {lane_active_state, sym_align_en});
  endtask

  // command then data back to back over four lanes, with masked words
  task automatic t_four();
    push({4{32'h0000_0000}} | 128'h0123_4567_89ab_cdef, 16'h00ff, 2'h0);
    push({4{32'hdead_beef}}, 16'hffff, 2'h1);
    push(128'hfedc_ba98_7654_3210_0f1e_2d3c_4b5a_6978, 16'hff00, 2'h2);
    eg_valid = 1'b0;
    pull(128'h0123_4567_89ab_cdef, 16'h00ff, 2'h0);
    pull({4{32'hdead_beef}}, 16'hffff, 2'h1);
    pull(128'hfedc_ba98_7654_3210_0f1e_2d3c_4b5a_6978, 16'hff00, 2'h2);
  endtask

  // illegal enables are dropped with a one-cycle reject
  task automatic t_reject();
    push({4{32'h5555_aaaa}}, 16'h0f0f, 2'h0);
    chk("reject partial", 1'b1, eg_reject);
    push({4{32'h5555_aaaa}}, 16'h0000, 2'h0);
    chk("reject empty", 1'b1, eg_reject);
    eg_valid = 1'b0;
    repeat (10) @(negedge clk);
    chk("nothing received", 1'b0, ig_valid);
    chk("reject cleared", 1'b0, eg_reject);
  endtask

  // ingress fifo holds four chunks, the fifth is dropped
  task automatic t_overflow();
    int d0;
    d0 = drops;
    for (int i = 0; i < 5; i++) push({4{32'(i + 16)}}, 16'hffff, 2'(i));
    eg_valid = 1'b0;
    repeat (10) @(negedge clk);
    chk("overflow drops", 1, drops - d0);
    for (int i = 0; i < 4; i++) pull({4{32'(i + 16)}}, 16'hffff, 2'(i));
  endtask

  // single bit error corrected, double error dropped
  task automatic t_ecc();
    int d0;
    int f0;
    d0 = drops;
    f0 = fixes;
    push({4{32'h3c3c_a5a5}}, 16'hffff, 2'h1);
    eg_valid = 1'b0;
    @(negedge clk);
    flip = 2'h1;
    @(negedge clk);
    flip = 2'h0;
    pull({4{32'h3c3c_a5a5}}, 16'hffff, 2'h1);
    chk("ecc corrections", 1, fixes - f0);
    push({4{32'hc3c3_5a5a}}, 16'hffff, 2'h2);
    eg_valid = 1'b0;
    @(negedge clk);
    flip = 2'h3;
    @(negedge clk);
    flip = 2'h0;
    repeat (10) @(negedge clk);
    chk("double error drop", {32'd1, 32'd1, 1'b0}, {32'(drops - d0), 32'(fixes - f0), ig_valid});
  endtask

  // single-lane operation
  task automatic t_single();
    rot = 2'h0;
    inv = 4'h0;
    do_reset(1'b0, 1'b0);
    repeat (4) @(negedge clk);
    push(128'h1111_2222_3333_4444_5555_6666_7777_8888, 16'hffff, 2'h3);
    push({4{32'h0f0f_f0f0}}, 16'h00ff, 2'h1);
    eg_valid = 1'b0;
    pull(128'h1111_2222_3333_4444_5555_6666_7777_8888, 16'hffff, 2'h3);
    pull({4{32'h0f0f_f0f0}}, 16'h00ff, 2'h1);
  endtask

  // internal loopback with the far end released
  task automatic t_loop();
    mute = 1'b1;
    do_reset(1'b1, 1'b1);
    repeat (4) @(negedge clk);
    push({2{64'h9abc_def0_1357_2468}}, 16'hffff, 2'h2);
    eg_valid = 1'b0;
    pull({2{64'h9abc_def0_1357_2468}}, 16'hffff, 2'h2);
  endtask

  initial begin
    t_sync();
    t_four();
    t_reject();
    t_overflow();
    t_ecc();
    t_single();
    t_loop();
    give_verdict();
  end
endmodule
